// File: hw/dcr_top.sv
// Two-channel device reservation and pending status tracker
`timescale 1ns/100ps
`include "dcr_map.svh"
module dcr_top #(
  parameter int N_MOD = `DCR_NUM_MOD
) (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  dcr_pkg::dcr_dp_t          dp,
  output logic [7:0]                a_bus_q,
  input  wire logic                 init_sel,
  input  wire logic                 second_channel_gated,
  input  dcr_pkg::dcr_cmd_t         cmd,
  input  wire logic                 sysrst_chan_a,
  input  wire logic                 sysrst_chan_b,
  input  wire logic                 seek_byte_valid,
  input  wire logic [7:0]           seek_byte,
  input  wire logic                 poll_enable_a,
  input  wire logic                 poll_enable_b,
  input  wire logic [N_MOD-1:0]     gated_attention,
  output dcr_pkg::dcr_status_t      status_q,
  output logic                      channel_b_active_flag_q,
  output logic [N_MOD-1:0]          seek_start_q,
  output logic [N_MOD-1:0]          gated_att_reset_q,
  output logic [15:0]               cylinder_target_reg_q,
  output logic [15:0]               head_target_reg_q,
  output logic [15:0]               diff_count_q,
  output logic [N_MOD-1:0]          attention_a_q,
  output logic [N_MOD-1:0]          attention_b_q,
  output logic                      request_in_a_q,
  output logic                      request_in_b_q
);
  if (N_MOD != `DCR_NUM_MOD) begin : g_bad_n
    $error("dcr_top supports exactly eight modules");
  end

  dcr_pkg::dcr_top_t t_q;
  dcr_pkg::dcr_top_t t_d;
  logic              seek_done;
  logic              seek_begin;

  function automatic dcr_pkg::dcr_status_t mk_status(
    input logic       chan_b,
    input logic       busy,
    input logic       ch_end,
    input logic       dev_end,
    input logic [2:0] idx
  );
    dcr_pkg::dcr_status_t s;
    s.valid      = 1'h1;
    s.chan_b     = chan_b;
    s.busy       = busy;
    s.ch_end     = ch_end;
    s.dev_end    = dev_end;
    s.module_idx = idx;
    return s;
  endfunction

  always_comb begin
    logic [2:0] own;
    logic [2:0] oth;
    logic [2:0] m;
    own        = `DCR_HALF_A;
    oth        = `DCR_HALF_B;
    m          = cmd.module_idx;
    t_d        = t_q;
    t_d.st     = '0;
    t_d.att_rst = '0;
    t_d.seek_go = '0;
    seek_begin = 1'h0;

    // Microprogram write lands first so that command effects win
    if (dp.we) begin
      t_d.sw[dp.dst_idx] = dp.d_bus;
    end

    if (init_sel) begin
      t_d.chb = second_channel_gated;
    end

    if (t_q.chb) begin
      own = `DCR_HALF_B;
      oth = `DCR_HALF_A;
    end

    case (t_q.fsm)
      dcr_pkg::ST_IDLE: begin
        if (cmd.valid) begin
          t_d.cur = m;
          case (cmd.op)
            dcr_pkg::OP_SELECT: begin
              if (t_d.sw[m][oth + `DCR_BIT_RES]) begin
                t_d.st = mk_status(t_q.chb, 1'h1, 1'h0, 1'h0, m);
                t_d.sw[m][own + `DCR_BIT_SC] = 1'h1;
              end else begin
                t_d.st = mk_status(t_q.chb, 1'h0, 1'h0, 1'h0, m);
              end
            end
            dcr_pkg::OP_RESERVE: begin
              if (t_d.sw[m][oth + `DCR_BIT_RES]) begin
                t_d.st = mk_status(t_q.chb, 1'h1, 1'h0, 1'h0, m);
                t_d.sw[m][own + `DCR_BIT_SC] = 1'h1;
              end else begin
                t_d.sw[m][own + `DCR_BIT_RES] = 1'h1;
                t_d.st = mk_status(t_q.chb, 1'h0, 1'h1, 1'h1, m);
              end
            end
            dcr_pkg::OP_RELEASE: begin
              // The other side's deferred end surfaces through polling
              t_d.sw[m][own + `DCR_BIT_RES] = 1'h0;
              t_d.st = mk_status(t_q.chb, 1'h0, 1'h1, 1'h1, m);
            end
            dcr_pkg::OP_SEEK: begin
              if (t_d.sw[m][oth + `DCR_BIT_RES]) begin
                t_d.st = mk_status(t_q.chb, 1'h1, 1'h0, 1'h0, m);
                t_d.sw[m][own + `DCR_BIT_SC] = 1'h1;
              end else begin
                seek_begin = 1'h1;
                t_d.fsm    = dcr_pkg::ST_SEEK;
              end
            end
            dcr_pkg::OP_ATTN: begin
              if (t_d.sw[m][own + `DCR_BIT_SK]) begin
                t_d.sw[m][own + `DCR_BIT_SC] = 1'h1;
                t_d.sw[m][own + `DCR_BIT_SK] = 1'h0;
              end else begin
                t_d.sw[m][own + `DCR_BIT_PC] = 1'h1;
              end
              // Record first, drop the line, present one cycle later
              t_d.att_rst[m] = 1'h1;
              t_d.fsm        = dcr_pkg::ST_ATTN_DE;
            end
            dcr_pkg::OP_DE_TAKEN: begin
              t_d.sw[m][own + `DCR_BIT_PC] = 1'h0;
              t_d.sw[m][own + `DCR_BIT_SC] = 1'h0;
            end
            dcr_pkg::OP_DE_STACKED: begin
              t_d.sw[m] = t_d.sw[m];
            end
            default: begin
              t_d.cur = t_q.cur;
            end
          endcase
        end
      end
      dcr_pkg::ST_SEEK: begin
        if (seek_done) begin
          t_d.fsm = dcr_pkg::ST_START;
        end
      end
      dcr_pkg::ST_START: begin
        t_d.seek_go[t_q.cur] = 1'h1;
        t_d.sw[t_q.cur][own + `DCR_BIT_SK] = 1'h1;
        t_d.st  = mk_status(t_q.chb, 1'h0, 1'h1, 1'h0, t_q.cur);
        t_d.fsm = dcr_pkg::ST_IDLE;
      end
      dcr_pkg::ST_ATTN_DE: begin
        t_d.st  = mk_status(t_q.chb, 1'h0, 1'h0, 1'h1, t_q.cur);
        t_d.fsm = dcr_pkg::ST_IDLE;
      end
      default: begin
        t_d.fsm = dcr_pkg::ST_IDLE;
      end
    endcase

    // Resets per channel leave the other half untouched
    for (int i = 0; i < N_MOD; i++) begin
      if (sysrst_chan_a) begin
        t_d.sw[i] = t_d.sw[i] & `DCR_LO_MASK;
      end
      if (sysrst_chan_b) begin
        t_d.sw[i] = t_d.sw[i] & `DCR_HI_MASK;
      end
    end

    t_d.a_bus = t_d.sw[dp.src_idx];
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      t_q     <= '0;
      t_q.fsm <= dcr_pkg::ST_IDLE;
    end else begin
      t_q <= t_d;
    end
  end

  dcr_seek_collect u_seek (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .start      (seek_begin),
    .byte_valid (seek_byte_valid),
    .seek_byte  (seek_byte),
    .done_q     (seek_done),
    .cyl_q      (cylinder_target_reg_q),
    .head_q     (head_target_reg_q),
    .diff_q     (diff_count_q)
  );

  dcr_attn #(
    .N_MOD (N_MOD)
  ) u_attn (
    .ref_clk         (ref_clk),
    .sys_rst         (sys_rst),
    .sw              (t_q.sw),
    .gated_attention (gated_attention),
    .poll_enable_a   (poll_enable_a),
    .poll_enable_b   (poll_enable_b),
    .att_a_q         (attention_a_q),
    .att_b_q         (attention_b_q),
    .req_a_q         (request_in_a_q),
    .req_b_q         (request_in_b_q)
  );

  assign a_bus_q                 = t_q.a_bus;
  assign status_q                = t_q.st;
  assign channel_b_active_flag_q = t_q.chb;
  assign seek_start_q            = t_q.seek_go;
  assign gated_att_reset_q       = t_q.att_rst;
endmodule

// File: pkg/dcr_map.svh
// Constants for the dual channel device reservation block
// Overview of operation
// - Channel B flags mirror A, upper nibble
// - State registers load D bus, drive A bus
// - State bits form per-module attention polling lines
// - Only second channel gating sets active flag
// - Reserve from B sets bit 4
// - A selecting B-reserved module gets busy
// - Refused A posts deferred device end, bit 2
// - Deferred device end idle while B reserves
// - B release lets A see device end
// - Reserve from A sets bit 0 if unreserved
// - Active flag picks which register half applies
// - Six seek bytes load cylinder, head, difference
// - Seek start sets seek-in-progress bit
// - Seek ends with channel end only
// - Gated attention plus poll enable raises request-in; code: B only with its bit 7 set, A not while only bit 7 is set
// - Seek attention sets bit 2, clears 3
// - Reset gated attention, then present device end
// - Command-out answer keeps pending device end
// - Release clears the channel's reservation bit
// - Non-seek attention sets pack-change bit until accepted
// - System reset clears only that channel's half
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_NUM_MOD   8
`define DCR_BIT_RES   3'h0
`define DCR_BIT_PC    3'h1
`define DCR_BIT_SC    3'h2
`define DCR_BIT_SK    3'h3
`define DCR_HALF_A    3'h0
`define DCR_HALF_B    3'h4
`define DCR_SW_RST    8'h00
`define DCR_LO_MASK   8'hF0
`define DCR_HI_MASK   8'h0F
`define DCR_SEEK_BYTES 3'h6
`define DCR_CYL_HI    3'h2
`define DCR_CYL_LO    3'h3
`define DCR_HEAD_HI   3'h4
`define DCR_HEAD_LO   3'h5
`endif

// File: pkg/dcr_pkg.sv
// Types shared by the dual channel device reservation block
package dcr_pkg;
  typedef enum logic [7:0] {
    OP_SELECT     = 8'h01,
    OP_RESERVE    = 8'h02,
    OP_RELEASE    = 8'h04,
    OP_SEEK       = 8'h08,
    OP_ATTN       = 8'h10,
    OP_DE_TAKEN   = 8'h20,
    OP_DE_STACKED = 8'h40,
    OP_NOP        = 8'h80
  } dcr_op_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SEEK    = 4'h2,
    ST_START   = 4'h4,
    ST_ATTN_DE = 4'h8
  } dcr_fsm_t;

  typedef struct packed {
    logic       valid;
    dcr_op_t    op;
    logic [2:0] module_idx;
  } dcr_cmd_t;

  typedef struct packed {
    logic       we;
    logic [2:0] dst_idx;
    logic [7:0] d_bus;
    logic [2:0] src_idx;
  } dcr_dp_t;

  typedef struct packed {
    logic       valid;
    logic       chan_b;
    logic       busy;
    logic       ch_end;
    logic       dev_end;
    logic [2:0] module_idx;
  } dcr_status_t;

  typedef struct packed {
    logic [7:0][7:0] sw;
    logic            chb;
    dcr_fsm_t        fsm;
    logic [2:0]      cur;
    dcr_status_t     st;
    logic [7:0]      a_bus;
    logic [7:0]      att_rst;
    logic [7:0]      seek_go;
  } dcr_top_t;

  typedef struct packed {
    logic [2:0]  cnt;
    logic        busy;
    logic [15:0] cyl;
    logic [15:0] head;
    logic [15:0] last_cyl;
    logic [15:0] diff;
    logic        done;
  } dcr_seek_t;

  typedef struct packed {
    logic [7:0] att_a;
    logic [7:0] att_b;
    logic       req_a;
    logic       req_b;
  } dcr_attn_t;
endpackage

// File: hw/dcr_seek_collect.sv
// Gathers the seek bytes and loads cylinder, head and difference
`timescale 1ns/100ps
`include "dcr_map.svh"
module dcr_seek_collect (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  seek_byte,
  output logic             done_q,
  output logic [15:0]      cyl_q,
  output logic [15:0]      head_q,
  output logic [15:0]      diff_q
);
  dcr_pkg::dcr_seek_t s_q;
  dcr_pkg::dcr_seek_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'h0;
    if (start) begin
      s_d.busy = 1'h1;
      s_d.cnt  = 3'h0;
    end else if (s_q.busy && byte_valid) begin
      case (s_q.cnt)
        `DCR_CYL_HI:  s_d.cyl[15:8]  = seek_byte;
        `DCR_CYL_LO:  s_d.cyl[7:0]   = seek_byte;
        `DCR_HEAD_HI: s_d.head[15:8] = seek_byte;
        `DCR_HEAD_LO: s_d.head[7:0]  = seek_byte;
        default:      s_d.cnt        = s_d.cnt;
      endcase
      s_d.cnt = s_q.cnt + 3'h1;
      if (s_d.cnt == `DCR_SEEK_BYTES) begin
        s_d.busy     = 1'h0;
        s_d.done     = 1'h1;
        s_d.last_cyl = s_d.cyl;
        // Distance from the last loaded cylinder; sign is dropped
        s_d.diff     = (s_d.cyl >= s_q.last_cyl) ? s_d.cyl - s_q.last_cyl
                                                 : s_q.last_cyl - s_d.cyl;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_q = s_q.done;
  assign cyl_q  = s_q.cyl;
  assign head_q = s_q.head;
  assign diff_q = s_q.diff;
endmodule

// File: hw/dcr_attn.sv
// Per-module attention lines and request-in for both channels
`timescale 1ns/100ps
`include "dcr_map.svh"
module dcr_attn #(
  parameter int N_MOD = `DCR_NUM_MOD
) (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire logic [N_MOD-1:0][7:0] sw,
  input  wire logic [N_MOD-1:0]      gated_attention,
  input  wire logic                  poll_enable_a,
  input  wire logic                  poll_enable_b,
  output logic [N_MOD-1:0]           att_a_q,
  output logic [N_MOD-1:0]           att_b_q,
  output logic                       req_a_q,
  output logic                       req_b_q
);
  dcr_pkg::dcr_attn_t a_q;
  dcr_pkg::dcr_attn_t a_d;
  logic [N_MOD-1:0] raw_a;
  logic [N_MOD-1:0] raw_b;

  genvar m;
  generate
    for (m = 0; m < N_MOD; m++) begin : g_mod
      // Reservation to the other side masks everything pending here
      assign raw_a[m] = ~sw[m][`DCR_HALF_B + `DCR_BIT_RES]
        & (sw[m][`DCR_HALF_A + `DCR_BIT_PC] | sw[m][`DCR_HALF_A + `DCR_BIT_SC]
        | (gated_attention[m] & (sw[m][`DCR_HALF_A + `DCR_BIT_SK]
        | ~sw[m][`DCR_HALF_B + `DCR_BIT_SK])));
      assign raw_b[m] = ~sw[m][`DCR_HALF_A + `DCR_BIT_RES]
        & (sw[m][`DCR_HALF_B + `DCR_BIT_PC] | sw[m][`DCR_HALF_B + `DCR_BIT_SC]
        | (gated_attention[m] & sw[m][`DCR_HALF_B + `DCR_BIT_SK]));
    end
  endgenerate

  always_comb begin
    a_d       = '0;
    a_d.att_a = raw_a;
    a_d.att_b = raw_b;
    a_d.req_a = (|raw_a) & poll_enable_a;
    a_d.req_b = (|raw_b) & poll_enable_b;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a_q <= '0;
    end else begin
      a_q <= a_d;
    end
  end

  assign att_a_q = a_q.att_a;
  assign att_b_q = a_q.att_b;
  assign req_a_q = a_q.req_a;
  assign req_b_q = a_q.req_b;
endmodule

// File: tb/dcr_checker.sv
// Port-level assertions for the reservation tracker
`timescale 1ns/100ps
module dcr_top_checker #(
  parameter int N_MOD = 8
) (
  input wire logic             ref_clk,
  input wire logic             sys_rst,
  input dcr_pkg::dcr_dp_t      dp,
  input wire logic [7:0]       a_bus_q,
  input wire logic             init_sel,
  input wire logic             second_channel_gated,
  input dcr_pkg::dcr_cmd_t     cmd,
  input wire logic             sysrst_chan_a,
  input wire logic             sysrst_chan_b,
  input wire logic             seek_byte_valid,
  input wire logic             poll_enable_a,
  input dcr_pkg::dcr_status_t  status_q,
  input wire logic             channel_b_active_flag_q,
  input wire logic [N_MOD-1:0] seek_start_q,
  input wire logic [N_MOD-1:0] gated_att_reset_q,
  input wire logic [N_MOD-1:0] attention_a_q,
  input wire logic             request_in_a_q
);
  logic [3:0] nbytes_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Bytes since last seek command
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (cmd.valid && cmd.op == dcr_pkg::OP_SEEK))
      nbytes_q <= 4'h0;
    else if (seek_byte_valid)
      nbytes_q <= nbytes_q + 4'h1;
  end
  AST_B_FLAG_SET: assert property ($rose(channel_b_active_flag_q) |->
    $past(init_sel && second_channel_gated)) else $error("flag set without B selection");
  AST_B_FLAG_CLR: assert property ($fell(channel_b_active_flag_q) |->
    $past(init_sel && !second_channel_gated)) else $error("flag cleared unexpectedly");
  // Only checked on quiet cycles, commands may override written bits
  AST_DBUS: assert property (dp.we && dp.dst_idx == dp.src_idx && !cmd.valid
    && !sysrst_chan_a && !sysrst_chan_b && !seek_byte_valid |=> a_bus_q == $past(dp.d_bus))
    else $error("write not seen on readback");
  AST_REQ_A: assert property (request_in_a_q |->
    (|attention_a_q) && $past(poll_enable_a)) else $error("request-in without cause");
  AST_SEEK_CE: assert property (|seek_start_q |->
    status_q.valid && status_q.ch_end && !status_q.dev_end) else $error("seek end status wrong");
  AST_SIX: assert property (|seek_start_q |-> nbytes_q == 4'h6)
    else $error("seek started without six bytes");
  AST_ATTN_DE: assert property (|gated_att_reset_q |=>
    status_q.valid && status_q.dev_end) else $error("no device end after attention reset");
  AST_BUSY: assert property (status_q.busy |-> status_q.valid && !status_q.dev_end)
    else $error("busy status malformed");
  AST_SYSRST_A: assert property (sysrst_chan_a |=> a_bus_q[3:0] == 4'h0)
    else $error("channel A half not cleared");
  COV_SEEK: cover property (|seek_start_q);
  COV_BUSY: cover property (status_q.busy);
  COV_REQ: cover property (request_in_a_q);
endmodule

bind dcr_top dcr_top_checker #(.N_MOD(N_MOD)) chk_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .dp(dp), .a_bus_q(a_bus_q), .init_sel(init_sel), .second_channel_gated(second_channel_gated),
  .cmd(cmd), .sysrst_chan_a(sysrst_chan_a), .seek_byte_valid(seek_byte_valid),
  .sysrst_chan_b(sysrst_chan_b),
  .poll_enable_a(poll_enable_a), .status_q(status_q),
  .channel_b_active_flag_q(channel_b_active_flag_q), .seek_start_q(seek_start_q),
  .gated_att_reset_q(gated_att_reset_q), .attention_a_q(attention_a_q),
  .request_in_a_q(request_in_a_q));

// File: tb/dcr_host_model.sv
// Host channel side streaming the seek bytes
`timescale 1ns/100ps
module dcr_host_model (
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic [47:0] bytes,
  output logic             seek_byte_valid,
  output logic [7:0]       seek_byte
);
  initial begin
    seek_byte_valid = 1'b0;
    seek_byte = 8'hA5;
    forever begin
      @(posedge ref_clk);
      if (start) begin
        for (int i = 0; i < 6; i++) begin
          seek_byte_valid <= 1'b1;
          seek_byte <= bytes[47-8*i -: 8];
          @(posedge ref_clk);
          // Gaps show a slow host; stale byte is inverted
          if (slow) begin
            seek_byte_valid <= 1'b0;
            seek_byte <= ~seek_byte;
            @(posedge ref_clk);
          end
        end
        seek_byte_valid <= 1'b0;
        seek_byte <= ~seek_byte;
      end
    end
  end
endmodule

// File: tb/dual_channel_device_reservation_bench.sv
// Self-checking bench for the reservation tracker
`timescale 1ns/100ps
module dual_channel_device_reservation_bench;
  logic                 ref_clk, sys_rst, init_sel, gated_b, rst_a, rst_b, poll_a, go, bv;
  logic                 chb_q, rq_a, rq_b;
  logic [7:0]           gatt, sb, a_bus, ss, gar, att_a, att_b, v, ss_seen, gar_seen;
  logic [15:0]          cyl, head, diff;
  logic [47:0]          bytes;
  dcr_pkg::dcr_dp_t     dp;
  dcr_pkg::dcr_cmd_t    cmd;
  dcr_pkg::dcr_status_t st, exp_q[$];
  int                   fails, compares, got, seed;
  dcr_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .dp(dp), .a_bus_q(a_bus),
    .init_sel(init_sel), .second_channel_gated(gated_b), .cmd(cmd), .sysrst_chan_a(rst_a),
    .sysrst_chan_b(rst_b), .seek_byte_valid(bv), .seek_byte(sb), .poll_enable_a(poll_a),
    .poll_enable_b(poll_a), .gated_attention(gatt), .status_q(st),
    .channel_b_active_flag_q(chb_q),
    .seek_start_q(ss), .gated_att_reset_q(gar), .cylinder_target_reg_q(cyl),
    .head_target_reg_q(head), .diff_count_q(diff), .attention_a_q(att_a),
    .attention_b_q(att_b), .request_in_a_q(rq_a), .request_in_b_q(rq_b));
  dcr_host_model host_u (.ref_clk(ref_clk), .start(go), .slow(1'b1), .bytes(bytes),
    .seek_byte_valid(bv), .seek_byte(sb));
  task automatic finish_test();
    // Expected statuses that never showed up count as misses
    fails += exp_q.size();
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_st(input dcr_pkg::dcr_status_t g, input dcr_pkg::dcr_status_t e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Status results are matched in issue order
  always @(posedge ref_clk) begin
    if (st.valid === 1'b1) begin
      got++;
      if (exp_q.size() == 0)
        chk_st(st, '0);
      else
        chk_st(st, exp_q.pop_front());
    end
    // Pulses last one cycle; keep the last one for later checks
    if (ss !== 8'h00) ss_seen <= ss;
    if (gar !== 8'h00) gar_seen <= gar;
  end
  // f holds expected {valid, busy, ch_end, dev_end}
  task automatic op(input dcr_pkg::dcr_op_t o, input logic [2:0] m, input logic b,
                    input logic [3:0] f);
    int n;
    n = got;
    if (f[3])
      exp_q.push_back({1'b1, b, f[2:0], m});
    @(posedge ref_clk) begin
      cmd <= '{1'b1, o, m};
      go <= (o == dcr_pkg::OP_SEEK) && !f[2];
    end
    @(posedge ref_clk) begin
      cmd.valid <= 1'b0;
      go <= 1'b0;
    end
    for (int i = 0; i < 40 && f[3] && got == n; i++) @(posedge ref_clk);
    if (f[3] && got == n) begin
      fails++;
      finish_test();
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic sel(input logic b);
    @(posedge ref_clk) begin
      init_sel <= 1'b1;
      gated_b <= b;
    end
    @(posedge ref_clk) init_sel <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge ref_clk) dp <= '{1'b1, i, d, i};
    @(posedge ref_clk) dp.we <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] i, input logic [7:0] e);
    @(posedge ref_clk) dp.src_idx <= i;
    repeat (2) @(posedge ref_clk);
    #1 chk({8'h0, a_bus}, {8'h0, e});
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
  initial begin
    seed = 32'h95B9A350;
    {sys_rst, init_sel, gated_b, rst_a, rst_b, poll_a, go} = 7'h40;
    gatt = 8'h00;
    dp = '0;
    cmd = '{1'b0, dcr_pkg::OP_NOP, 3'h0};
    bytes = {16'($random(seed)), $random(seed)};
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    chk(16'(chb_q), 16'h0);
    sel(1'b1);
    chk(16'(chb_q), 16'h1);
    op(dcr_pkg::OP_RESERVE, 3'h2, 1'b1, 4'hB);
    rd(3'h2, 8'h10);
    sel(1'b0);
    chk(16'(chb_q), 16'h0);
    op(dcr_pkg::OP_SELECT, 3'h2, 1'b0, 4'hC);
    rd(3'h2, 8'h14);
    chk(16'(att_a[2]), 16'h0);
    @(posedge ref_clk) poll_a <= 1'b1;
    sel(1'b1);
    op(dcr_pkg::OP_RELEASE, 3'h2, 1'b1, 4'hB);
    rd(3'h2, 8'h04);
    chk(16'(att_a[2]), 16'h1);
    chk(16'(rq_a), 16'h1);
    sel(1'b0);
    op(dcr_pkg::OP_DE_TAKEN, 3'h2, 1'b0, 4'h0);
    rd(3'h2, 8'h00);
    $display("Reservation test done");
    op(dcr_pkg::OP_RESERVE, 3'h5, 1'b0, 4'hB);
    rd(3'h5, 8'h01);
    op(dcr_pkg::OP_SEEK, 3'h5, 1'b0, 4'hA);
    rd(3'h5, 8'h09);
    chk(16'(ss_seen), 16'h20);
    chk(cyl, bytes[31:16]);
    chk(head, bytes[15:0]);
    chk(diff, bytes[31:16]);
    @(posedge ref_clk) gatt <= 8'h20;
    op(dcr_pkg::OP_ATTN, 3'h5, 1'b0, 4'h9);
    chk(16'(gar_seen), 16'h20);
    @(posedge ref_clk) gatt <= 8'h00;
    rd(3'h5, 8'h05);
    op(dcr_pkg::OP_DE_STACKED, 3'h5, 1'b0, 4'h0);
    rd(3'h5, 8'h05);
    @(posedge ref_clk) gatt <= 8'h08;
    op(dcr_pkg::OP_ATTN, 3'h3, 1'b0, 4'h9);
    chk(16'(gar_seen), 16'h08);
    @(posedge ref_clk) gatt <= 8'h00;
    rd(3'h3, 8'h02);
    sel(1'b1);
    op(dcr_pkg::OP_RESERVE, 3'h5, 1'b1, 4'hC);
    rd(3'h5, 8'h45);
    op(dcr_pkg::OP_SEEK, 3'h5, 1'b1, 4'hC);
    $display("Seek test done");
    v = 8'($random(seed));
    wr(3'h7, v);
    rd(3'h7, v);
    @(posedge ref_clk) rst_a <= 1'b1;
    @(posedge ref_clk) rst_a <= 1'b0;
    rd(3'h7, v & 8'hF0);
    chk(16'(att_b), 16'({v[5] | v[6], 2'h1, 5'h00}));
    chk(16'(rq_b), 16'h1);
    @(posedge ref_clk) rst_b <= 1'b1;
    @(posedge ref_clk) rst_b <= 1'b0;
    rd(3'h5, 8'h00);
    chk(16'(att_b), 16'h00);
    op(dcr_pkg::OP_SELECT, 3'h3, 1'b1, 4'h8);
    $display("Register test done");
    finish_test();
  end
endmodule
